// File: design/pfsr_pkg.sv
`default_nettype none
package pfsr_pkg;
  // Management register indices
  localparam logic [4:0]  REG_BMC       = 5'h00;
  localparam logic [4:0]  REG_BMS       = 5'h01;
  localparam logic [4:0]  REG_EXT_ADDR  = 5'h0d;
  localparam logic [4:0]  REG_EXT_DATA  = 5'h0e;
  localparam logic [4:0]  REG_LED_ROUTE = 5'h18;
  localparam logic [4:0]  REG_RST_CTRL  = 5'h1f;
  localparam logic [15:0] EXT_FIBER_STAT = 16'h00fd;
  localparam logic [15:0] EXT_FIBER_MAN  = 16'h0102;
  // Field positions
  localparam int BMC_RESET   = 15;
  localparam int BMC_AN_EN   = 12;
  localparam int BMC_AN_RST  = 8;
  localparam int BMS_AN_DONE = 5;
  localparam int BMS_LINK    = 2;
  localparam int RCR_HI      = 15;
  localparam int RCR_LO      = 14;
  localparam int FS_AUTO     = 9;
  localparam int FM_EN       = 15;
  localparam int FM_VAL      = 14;
  localparam int LR_ACT_COL  = 0;
  localparam int LR_COL_OFF  = 1;
  // Reset and fixed values
  localparam logic [15:0] BMC_DEFAULT  = 16'h1000;
  localparam logic [15:0] BMS_FIXED    = 16'h0000;
  localparam logic [2:0]  FS_RSVD_HI   = 3'h3;
  localparam logic [8:0]  FS_RSVD_LO   = 9'h164;
  localparam logic [13:0] FM_RSVD      = 14'h0200;
  localparam logic [15:0] ZERO16       = 16'h0000;
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int RST_DONE_US   = 200;
  localparam int RST_DONE_CYC  = (RST_DONE_US * 1000) / CLK_PERIOD_NS;
  localparam int RST_CNT_W     = 14;
  localparam logic [13:0] STRAP_CAPTURE_CYC = 14'h0003;
  localparam logic [6:0]  FEF_ONES   = 7'h54;
  localparam int          BLINK_MSB  = 20;
  localparam logic [19:0] ACT_HOLD   = 20'hfffff;
  // Management frame
  localparam logic [3:0]  HDR_LAST   = 4'hc;
  localparam logic [3:0]  DATA_LAST  = 4'hf;
  localparam logic [1:0]  OP_READ    = 2'h2;
  localparam logic [1:0]  OP_WRITE   = 2'h1;

  typedef enum logic [1:0] {
    MF_IDLE = 2'b00,
    MF_HDR  = 2'b01,
    MF_TA   = 2'b11,
    MF_DATA = 2'b10
  } pfsr_mf_state_t;

  // Status from the fiber datapath, same clock
  typedef struct packed {
    logic fef_detect;
    logic pecl_violation;
    logic pecl_valid;
    logic activity;
    logic collision;
    logic link_up;
  } pfsr_line_t;

  function automatic logic ext_hit(input logic [4:0]  regad,
                                   input logic [15:0] ext_addr,
                                   input logic [15:0] target);
    ext_hit = (regad == REG_EXT_DATA) && (ext_addr == target);
  endfunction : ext_hit
endpackage : pfsr_pkg
`default_nettype wire

// File: design/pfsr_top.sv
// Behaviour
// - Hardware reset restores registers, relatches straps.
// - Ready about 200 us after reset release.
// - Control bit 15 write resets management state.
// - Reset control bits 15,14 digital reset.
// - Status bit 5 reports autonegotiation complete.
// - Answer only frames carrying strapped station address.
// - Mode strap low MII, high reduced interface.
// - Five address straps captured at hardware reset.
// - Link indicator steady on, blinks on activity.
// - Activity moves to collision pin when disabled.
// - Remote fault detection latches bit 15 high.
// - Optical signalling violation latches bit 14 high.
// - Detect bit latches low, read refreshes it.
// - Auto detect treats valid signalling as detect.
// - Manual detect enable bit, resets to zero.
// - Manual value overrides every other detect source.
// - Low bits fixed 0x200, writes ignored.
// - Fault pattern: 84 ones then one zero.
// - No signal detect sends remote fault indication.
`timescale 1ns/1ps
`default_nettype none
module pfsr_top #(
  parameter int unsigned RST_WAIT = pfsr_pkg::RST_DONE_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 mdc_i,
  input  wire logic                 mdio_i,
  output var  logic                 mdio_o,
  output var  logic                 mdio_oe_o,
  input  wire logic [4:0]           station_address_strap_i,
  input  wire logic                 rmii_strap_i,
  input  wire logic                 signal_detect_input_i,
  input  wire pfsr_pkg::pfsr_line_t line_i,
  output var  logic                 link_indicator_pin_o,
  output var  logic                 col_pin_o,
  output var  logic                 rmii_mode_o,
  output var  logic                 fiber_link_o,
  output var  logic                 remote_fault_indication_o,
  output var  logic                 fef_tx_en_o,
  output var  logic                 ready_o
);
  import pfsr_pkg::*;

  // Pin synchronisers: mdc, mdio, detect, mode strap, address straps
  logic [8:0] sync1;
  logic [8:0] sync2;
  logic       mdc_d;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1 <= 9'h000;
      sync2 <= 9'h000;
      mdc_d <= 1'b0;
    end else begin
      sync1 <= {mdc_i, mdio_i, signal_detect_input_i, rmii_strap_i,
                station_address_strap_i};
      sync2 <= sync1;
      mdc_d <= sync2[8];
    end
  end
  logic mdio_s;
  logic sd_s;
  logic mdc_rise;
  assign mdio_s   = sync2[7];
  assign sd_s     = sync2[6];
  assign mdc_rise = sync2[8] & ~mdc_d;

  // Reset completion and strap capture
  logic [RST_CNT_W-1:0] rst_cnt;
  logic [4:0]           station_addr;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_cnt <= '0;
      ready_o <= 1'b0;
    end else if (!ready_o) begin
      rst_cnt <= rst_cnt + 1'b1;
      if (rst_cnt == RST_CNT_W'(RST_WAIT - 1)) begin
        ready_o <= 1'b1;
      end
    end
  end

  // Straps settle through the synchroniser before capture
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      station_addr <= 5'h00;
      rmii_mode_o  <= 1'b0;
    end else if (!ready_o && rst_cnt == STRAP_CAPTURE_CYC) begin
      station_addr <= sync2[4:0];
      rmii_mode_o  <= sync2[5];
    end
  end

  // Management frame engine
  pfsr_mf_state_t state;
  logic [3:0]     bit_cnt;
  logic [12:0]    hdr_sr;
  logic [15:0]    data_sr;
  logic           wr_pulse;
  logic           rd_pulse;
  logic [15:0]    wr_data;
  logic [15:0]    rdata;
  logic           hdr_ok;
  logic           op_rd;
  logic           op_wr;
  assign op_rd  = hdr_sr[11:10] == OP_READ;
  assign op_wr  = hdr_sr[11:10] == OP_WRITE;
  assign hdr_ok = hdr_sr[12] && (hdr_sr[9:5] == station_addr);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state     <= MF_IDLE;
      bit_cnt   <= 4'h0;
      hdr_sr    <= 13'h0000;
      data_sr   <= ZERO16;
      mdio_o    <= 1'b0;
      mdio_oe_o <= 1'b0;
      wr_pulse  <= 1'b0;
      rd_pulse  <= 1'b0;
      wr_data   <= ZERO16;
    end else begin
      wr_pulse <= 1'b0;
      rd_pulse <= 1'b0;
      if (mdc_rise) begin
        unique case (state)
          MF_IDLE: begin
            // Start bit; frames before ready are ignored
            if (ready_o && !mdio_s) begin
              state   <= MF_HDR;
              bit_cnt <= 4'h0;
            end
          end
          MF_HDR: begin
            hdr_sr  <= {hdr_sr[11:0], mdio_s};
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == HDR_LAST) begin
              state   <= MF_TA;
              bit_cnt <= 4'h0;
            end
          end
          MF_TA: begin
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == 4'h0) begin
              mdio_o    <= 1'b0;
              mdio_oe_o <= hdr_ok && op_rd;
            end else begin
              state   <= MF_DATA;
              bit_cnt <= 4'h0;
              data_sr <= rdata;
              mdio_o  <= rdata[15];
              rd_pulse <= hdr_ok && op_rd;
            end
          end
          MF_DATA: begin
            bit_cnt <= bit_cnt + 1'b1;
            mdio_o  <= data_sr[14];
            data_sr <= {data_sr[14:0], mdio_s};
            if (bit_cnt == DATA_LAST) begin
              state     <= MF_IDLE;
              mdio_oe_o <= 1'b0;
              wr_pulse  <= hdr_ok && op_wr;
              wr_data   <= {data_sr[14:0], mdio_s};
            end
          end
        endcase
      end
    end
  end

  logic [4:0] regad;
  assign regad = hdr_sr[4:0];

  // Register state
  logic [15:0] bmc;
  logic [15:0] ext_addr;
  logic [1:0]  led_route;
  logic        auto_sd;
  logic        man_en;
  logic        man_val;
  logic        soft_rst;
  logic        an_done;
  logic        fef_l;
  logic        pecl_l;
  logic        sd_l;
  logic        rd_stat;
  assign rd_stat = rd_pulse && ext_hit(regad, ext_addr, EXT_FIBER_STAT);

  // Either reset request clears the writable state two cycles after the write pulse
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_pulse &&
        ((regad == REG_BMC && wr_data[BMC_RESET]) ||
         (regad == REG_RST_CTRL && wr_data[RCR_HI] &&
          wr_data[RCR_LO]));
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bmc       <= BMC_DEFAULT;
      ext_addr  <= ZERO16;
      led_route <= 2'h0;
      auto_sd   <= 1'b0;
      man_en    <= 1'b0;
      man_val   <= 1'b0;
    end else if (soft_rst) begin
      bmc       <= BMC_DEFAULT;
      ext_addr  <= ZERO16;
      led_route <= 2'h0;
      auto_sd   <= 1'b0;
      man_en    <= 1'b0;
      man_val   <= 1'b0;
    end else if (wr_pulse) begin
      if (regad == REG_BMC) begin
        bmc <= {1'b0, wr_data[14:0]};
      end
      if (regad == REG_EXT_ADDR) begin
        ext_addr <= wr_data;
      end
      if (regad == REG_LED_ROUTE) begin
        led_route <= wr_data[1:0];
      end
      if (ext_hit(regad, ext_addr, EXT_FIBER_STAT)) begin
        auto_sd <= wr_data[FS_AUTO];
      end
      if (ext_hit(regad, ext_addr, EXT_FIBER_MAN)) begin
        man_en  <= wr_data[FM_EN];
        man_val <= wr_data[FM_VAL];
      end
    end else begin
      // Restart is a one-shot command
      bmc[BMC_AN_RST] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      an_done <= 1'b0;
    end else if (soft_rst || bmc[BMC_AN_RST] || !line_i.link_up) begin
      an_done <= 1'b0;
    end else if (bmc[BMC_AN_EN]) begin
      an_done <= 1'b1;
    end
  end

  // Latched status: an event in the clearing read cycle wins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fef_l  <= 1'b0;
      pecl_l <= 1'b0;
      sd_l   <= 1'b0;
    end else begin
      fef_l  <= line_i.fef_detect | (fef_l & ~rd_stat);
      pecl_l <= line_i.pecl_violation | (pecl_l & ~rd_stat);
      sd_l   <= rd_stat ? sd_s : (sd_l & sd_s);
    end
  end

  always_comb begin
    rdata = ZERO16;
    unique case (regad)
      REG_BMC:       rdata = {1'b0, bmc[14:0]};
      REG_BMS:       rdata = BMS_FIXED |
                             (16'(an_done) << BMS_AN_DONE) |
                             (16'(line_i.link_up) << BMS_LINK);
      REG_EXT_ADDR:  rdata = ext_addr;
      REG_LED_ROUTE: rdata = {14'h0000, led_route};
      REG_EXT_DATA: begin
        if (ext_addr == EXT_FIBER_STAT) begin
          rdata = {fef_l, pecl_l, sd_l, FS_RSVD_HI, auto_sd, FS_RSVD_LO};
        end else if (ext_addr == EXT_FIBER_MAN) begin
          rdata = {man_en, man_val, FM_RSVD};
        end
      end
      default:       rdata = ZERO16;
    endcase
  end

  // Effective signal detect and remote fault transmit
  logic       sd_eff;
  logic [6:0] fef_cnt;
  assign sd_eff = man_en ? man_val :
                  (sd_s | (auto_sd & line_i.pecl_valid));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fiber_link_o              <= 1'b0;
      fef_tx_en_o               <= 1'b0;
      remote_fault_indication_o <= 1'b0;
      fef_cnt                   <= 7'h00;
    end else begin
      fiber_link_o <= sd_eff;
      fef_tx_en_o  <= ~sd_eff;
      if (!sd_eff) begin
        fef_cnt <= (fef_cnt == FEF_ONES) ? 7'h00 : fef_cnt + 1'b1;
        remote_fault_indication_o <= fef_cnt != FEF_ONES;
      end else begin
        fef_cnt                   <= 7'h00;
        remote_fault_indication_o <= 1'b0;
      end
    end
  end

  // Indicators
  logic [BLINK_MSB:0] blink_cnt;
  logic [19:0]        act_cnt;
  logic               act_on;
  logic               route_col;
  logic               blink_on;
  assign act_on    = act_cnt != 20'h00000;
  // Blink phase is the lower half of the free-running blink_cnt, which a burst does not restart
  assign blink_on  = ~blink_cnt[BLINK_MSB];
  // Routing only takes effect with the collision function off
  assign route_col = led_route[LR_ACT_COL] & led_route[LR_COL_OFF];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blink_cnt            <= '0;
      act_cnt              <= 20'h00000;
      link_indicator_pin_o <= 1'b0;
      col_pin_o            <= 1'b0;
    end else begin
      blink_cnt <= blink_cnt + 1'b1;
      act_cnt   <= line_i.activity ? ACT_HOLD :
                   (act_on ? act_cnt - 1'b1 : act_cnt);
      link_indicator_pin_o <= line_i.link_up &
        ~(act_on & ~route_col & blink_on);
      col_pin_o <= route_col ? (act_on & blink_on) :
                   (~led_route[LR_COL_OFF] & line_i.collision);
    end
  end

  // Checks
  ready_time_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(ready_o) |-> $past(rst_cnt) == RST_CNT_W'(RST_WAIT - 1))
    else $error("ready rose at wrong count");
  strap_cap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!ready_o && rst_cnt == STRAP_CAPTURE_CYC) |=>
    station_addr == $past(sync2[4:0]))
    else $error("address strap not captured");
  bmc_reset_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_pulse && regad == REG_BMC && wr_data[BMC_RESET]) |=> ##1
    (bmc == BMC_DEFAULT && !man_en && !auto_sd))
    else $error("control reset did not restore defaults");
  dig_reset_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_pulse && regad == REG_RST_CTRL && wr_data[RCR_HI] &&
     wr_data[RCR_LO]) |=> soft_rst ##1 (led_route == 2'h0))
    else $error("digital reset not applied");
  addr_match_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mdio_oe_o |-> hdr_sr[9:5] == station_addr)
    else $error("answered foreign address");
  fef_latch_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    line_i.fef_detect |=> fef_l)
    else $error("remote fault not latched");
  pecl_latch_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    line_i.pecl_violation |=> pecl_l)
    else $error("signalling violation not latched");
  sd_low_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !sd_s |=> !sd_l)
    else $error("detect drop not latched low");
  manual_sd_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    man_en |=> fiber_link_o == $past(man_val))
    else $error("manual detect not obeyed");
  fef_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!sd_eff && fef_cnt == FEF_ONES) |=> !remote_fault_indication_o)
    else $error("fault pattern zero missing");
  fef_send_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !sd_eff |=> fef_tx_en_o)
    else $error("fault indication not sent");
  an_done_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    bmc[BMC_AN_RST] |=> !an_done)
    else $error("restart did not clear completion");

  rd_frame_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_pulse && regad == REG_BMS);
  wr_frame_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_pulse && ext_hit(regad, ext_addr, EXT_FIBER_MAN));
  fef_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    fef_tx_en_o && !remote_fault_indication_o);
endmodule : pfsr_top
`default_nettype wire

// File: sim/pfsr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfsr_host_model (
  input  wire logic clk_i,
  input  wire logic dev_mdio_i,
  input  wire logic dev_oe_i,
  output var  logic mdc_o,
  output var  logic mdio_o
);
  logic drv_en;
  logic drv_bit;

  // Pull-up holds the shared line high whenever nobody drives it
  always_comb mdio_o = dev_oe_i ? dev_mdio_i : (drv_en ? drv_bit : 1'b1);

  initial begin
    mdc_o   = 1'b0;
    drv_en  = 1'b0;
    drv_bit = 1'b1;
  end

  // Clock stands low between frames; the low half lasts 5 cycles, the high half 6
  task automatic xfer(input  logic        rd,
                      input  logic [4:0]  phy,
                      input  logic [4:0]  ra,
                      input  logic [15:0] wd,
                      output logic [15:0] q);
    logic [33:0] f;
    f = {4'b1101, rd ? 2'b10 : 2'b01, phy, ra, 2'b10, wd};
    q = 16'h0000;
    for (int i = 33; i >= 0; i--) begin
      @(negedge clk_i);
      mdc_o   = 1'b0;
      drv_en  = !(rd && i <= 17);
      drv_bit = f[i];
      repeat (5) @(negedge clk_i);
      if (i <= 15) q[i] = mdio_o;
      mdc_o = 1'b1;
      repeat (5) @(negedge clk_i);
    end
    @(negedge clk_i);
    mdc_o  = 1'b0;
    drv_en = 1'b0;
    repeat (8) @(negedge clk_i);
  endtask : xfer
endmodule : pfsr_host_model
`default_nettype wire

// File: sim/pfsr_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pfsr_tb_top;
  import pfsr_pkg::*;
  logic             clk;
  logic             rst_n;
  logic             mdc;
  logic             mdio;
  logic             dev_mdio;
  logic             dev_oe;
  logic [4:0]       straps;
  logic             rmii_strap;
  logic             sd_pin;
  pfsr_line_t       line;
  logic             link_ind;
  logic             col_pin;
  logic             rmii_mode;
  logic             fiber_link;
  logic             fault_bit;
  logic             fault_tx_en;
  logic             ready;
  logic [4:0]       addr;
  logic [4:0]       tgt;
  logic [31:0]      x;
  logic             m_fault;
  logic             m_sig;
  logic             m_det;
  logic             m_auto;
  int               fails;
  int               n_tests;

  pfsr_top #(.RST_WAIT(20)) pfsr_top_inst (
    .clk_i(clk), .rst_n_i(rst_n), .mdc_i(mdc), .mdio_i(mdio),
    .mdio_o(dev_mdio), .mdio_oe_o(dev_oe),
    .station_address_strap_i(straps), .rmii_strap_i(rmii_strap),
    .signal_detect_input_i(sd_pin), .line_i(line),
    .link_indicator_pin_o(link_ind), .col_pin_o(col_pin),
    .rmii_mode_o(rmii_mode), .fiber_link_o(fiber_link),
    .remote_fault_indication_o(fault_bit), .fef_tx_en_o(fault_tx_en),
    .ready_o(ready));

  pfsr_host_model pfsr_host_model_inst (
    .clk_i(clk), .dev_mdio_i(dev_mdio), .dev_oe_i(dev_oe),
    .mdc_o(mdc), .mdio_o(mdio));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : rnd

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] q;
    pfsr_host_model_inst.xfer(1'b1, tgt, ra, 16'h0000, q);
    chk(q, exp);
  endtask : rd

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] q;
    pfsr_host_model_inst.xfer(1'b0, tgt, ra, d, q);
  endtask : wr

  task automatic ext_wr(input logic [15:0] a, input logic [15:0] d);
    wr(REG_EXT_ADDR, a);
    wr(REG_EXT_DATA, d);
  endtask : ext_wr

  task automatic ext_rd(input logic [15:0] a, input logic [15:0] exp);
    wr(REG_EXT_ADDR, a);
    rd(REG_EXT_DATA, exp);
  endtask : ext_rd

  // Latched bits clear on read, detect bit reloads from the pin
  task automatic fd_rd();
    ext_rd(EXT_FIBER_STAT, {m_fault, m_sig, m_det, 3'b011, m_auto, 9'h164});
    m_fault = 1'b0;
    m_sig   = 1'b0;
    m_det   = sd_pin;
  endtask : fd_rd

  task automatic fault_pattern();
    int n;
    n = 0;
    while (fault_bit !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    for (int i = 0; i < 85; i++) begin
      @(negedge clk);
      chk(fault_bit, (i == 84) ? 16'h0000 : 16'h0001);
    end
  endtask : fault_pattern

  task automatic conclude();
    $display("compares %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    conclude();
  end

  initial begin
    logic [15:0] vals[$];
    x = 32'h7fd1ff64;
    fails = 0;
    n_tests = 0;
    rst_n = 1'b0;
    rmii_strap = 1'b1;
    sd_pin = 1'b0;
    line = '0;
    {m_fault, m_sig, m_det, m_auto} = 4'h0;
    addr = rnd() % 32;
    tgt = addr;
    straps = addr;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    chk(ready, 16'h0000);
    repeat (15) @(negedge clk);
    chk(ready, 16'h0001);
    chk(rmii_mode, 16'h0001);
    chk(fault_tx_en, 16'h0001);
    rd(REG_BMC, BMC_DEFAULT);
    rd(REG_BMS, 16'h0000);
    rd(REG_RST_CTRL, 16'h0000);
    $display("test reset done");
    straps = ~addr;
    rd(REG_BMC, BMC_DEFAULT);
    tgt = addr ^ 5'h01;
    rd(REG_BMC, 16'hffff);
    tgt = addr;
    $display("test address done");
    sd_pin = 1'b1;
    fd_rd();
    fd_rd();
    chk(fault_tx_en, 16'h0000);
    line.fef_detect = 1'b1;
    line.pecl_violation = 1'b1;
    sd_pin = 1'b0;
    @(negedge clk);
    line.fef_detect = 1'b0;
    line.pecl_violation = 1'b0;
    {m_fault, m_sig, m_det} = 3'b110;
    repeat (4) @(negedge clk);
    chk(fiber_link, 16'h0000);
    chk(fault_tx_en, 16'h0001);
    fault_pattern();
    fd_rd();
    fd_rd();
    ext_wr(EXT_FIBER_STAT, 16'h0200);
    m_auto = 1'b1;
    line.pecl_valid = 1'b1;
    repeat (3) @(negedge clk);
    chk(fiber_link, 16'h0001);
    $display("test fiber status done");
    vals = {rnd(), rnd(), 16'h8000, 16'hc000};
    foreach (vals[k]) begin
      ext_wr(EXT_FIBER_MAN, vals[k]);
      ext_rd(EXT_FIBER_MAN, {vals[k][15:14], 14'h0200});
      chk(fiber_link, vals[k][15] ? vals[k][14] : 1'b1);
    end
    wr(REG_BMC, 16'h8000);
    ext_rd(EXT_FIBER_MAN, 16'h0200);
    m_auto = 1'b0;
    fd_rd();
    rd(REG_BMC, BMC_DEFAULT);
    ext_wr(EXT_FIBER_MAN, 16'hc000);
    wr(REG_RST_CTRL, 16'h8000);
    ext_rd(EXT_FIBER_MAN, 16'hc200);
    wr(REG_RST_CTRL, 16'hc000);
    repeat (20000) @(negedge clk);
    ext_rd(EXT_FIBER_MAN, 16'h0200);
    $display("test detect control done");
    line.link_up = 1'b1;
    wr(REG_BMC, 16'h1100);
    rd(REG_BMS, 16'h0024);
    rd(REG_BMC, BMC_DEFAULT);
    line.link_up = 1'b0;
    rd(REG_BMS, 16'h0000);
    $display("test autoneg done");
    line.link_up = 1'b1;
    repeat (4) @(negedge clk);
    chk(link_ind, 16'h0001);
    wr(REG_LED_ROUTE, 16'h0003);
    line.activity = 1'b1;
    @(negedge clk);
    line.activity = 1'b0;
    repeat (4) @(negedge clk);
    chk(col_pin, 16'h0001);
    chk(link_ind, 16'h0001);
    wr(REG_LED_ROUTE, 16'h0001);
    chk(col_pin, 16'h0000);
    line.collision = 1'b1;
    repeat (3) @(negedge clk);
    chk(col_pin, 16'h0001);
    chk(link_ind, 16'h0000);
    line.collision = 1'b0;
    $display("test led done");
    addr = addr ^ 5'h11;
    tgt = addr;
    straps = addr;
    rmii_strap = 1'b0;
    rst_n = 1'b0;
    repeat (41) @(negedge clk);
    rst_n = 1'b1;
    repeat (30) @(negedge clk);
    chk(rmii_mode, 16'h0000);
    rd(REG_LED_ROUTE, 16'h0000);
    rd(REG_BMC, BMC_DEFAULT);
    $display("test hardware reset done");
    conclude();
  end
endmodule : pfsr_tb_top
`default_nettype wire
